// ### cnm_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module cnm_adc_model (
    // bench control
    input wire logic clk_in,
    input wire logic fire_in,
    input wire logic [11:0] seq_in,
    // sample ports a..d
    output logic [15:0] mant_out [0:3],
    output logic [2:0] exp_out [0:3],
    output logic vld_out
);
    initial begin
        vld_out = 1'b0;
        for (int k = 0; k < 4; k++) begin
            mant_out[k] = 16'h0000;
            exp_out[k] = 3'h0;
        end
    end
    // all ports sample together; idle data toggles so stale values never look valid
    always @(posedge clk_in) begin
        vld_out <= fire_in;
        for (int k = 0; k < 4; k++) begin
            mant_out[k] <= fire_in ? {4'(k), seq_in} : ~mant_out[k];
            exp_out[k] <= fire_in ? 3'(k + 1) : ~exp_out[k];
        end
    end
endmodule // cnm_adc_model
`default_nettype wire

// ### cnm_channel_nco_mixer.v
`timescale 1ns/1ps
`default_nettype none
`include "cnm_defines.vh"

module cnm_channel_nco_mixer #(
    parameter MANT_W = `CNM_MANT_W,
    parameter EXP_W = `CNM_EXP_W
) (
    // clock and reset
    input wire clk_in,
    input wire srst_in,
    // adc sample ports, from outside the clock domain
    input wire [MANT_W-1:0] port_a_mant_in,
    input wire [EXP_W-1:0] port_a_exp_in,
    input wire port_a_vld_in,
    input wire [MANT_W-1:0] port_b_mant_in,
    input wire [EXP_W-1:0] port_b_exp_in,
    input wire port_b_vld_in,
    input wire [MANT_W-1:0] port_c_mant_in,
    input wire [EXP_W-1:0] port_c_exp_in,
    input wire port_c_vld_in,
    input wire [MANT_W-1:0] port_d_mant_in,
    input wire [EXP_W-1:0] port_d_exp_in,
    input wire port_d_vld_in,
    // sync events, from outside the clock domain
    input wire sleep_in,
    input wire hop_sync_in,
    // register port
    input wire tuning_word_wr_in,
    input wire [`CNM_FREQ_W-1:0] tuning_word_in,
    input wire [`CNM_HOLD_W-1:0] frequency_update_delay_in,
    input wire [`CNM_POFS_W-1:0] oscillator_phase_offset_in,
    input wire [`CNM_SEL_W-1:0] source_sel_in,
    input wire complex_sel_in,
    input wire osc_bypass_in,
    input wire clear_acc_in,
    input wire phase_dither_en_in,
    input wire amp_dither_en_in,
    // status
    output reg [`CNM_FREQ_W-1:0] tuning_shadow_out,
    output reg [`CNM_FREQ_W-1:0] tuning_active_out,
    output reg update_pending_out,
    // channel output toward the filters
    output reg [MANT_W-1:0] chan_i_out,
    output reg [MANT_W-1:0] chan_q_out,
    output reg [EXP_W-1:0] chan_exp_out,
    output reg chan_cplx_out,
    output reg chan_vld_out
);

    localparam PORT_W = MANT_W + EXP_W + 1;
    localparam RAW_W = 4 * PORT_W + 2;
    localparam ST_IDLE = 2'b01;
    localparam ST_COUNT = 2'b10;

    // every adc port and sync event level passes two flops before use
    wire [RAW_W-1:0] raw_w = {sleep_in, hop_sync_in,
        port_d_vld_in, port_d_exp_in, port_d_mant_in,
        port_c_vld_in, port_c_exp_in, port_c_mant_in,
        port_b_vld_in, port_b_exp_in, port_b_mant_in,
        port_a_vld_in, port_a_exp_in, port_a_mant_in};
    reg [RAW_W-1:0] meta_r;
    reg [RAW_W-1:0] sync_r;
    reg sleep_d_r;
    reg hop_d_r;

    always @(posedge clk_in) begin
        if (srst_in) begin
            meta_r <= {RAW_W{1'b0}};
            sync_r <= {RAW_W{1'b0}};
            sleep_d_r <= 1'b0;
            hop_d_r <= 1'b0;
        end else begin
            meta_r <= raw_w;
            sync_r <= meta_r;
            sleep_d_r <= sync_r[RAW_W-1];
            hop_d_r <= sync_r[RAW_W-2];
        end
    end

    wire [PORT_W-1:0] pa_w = sync_r[PORT_W-1:0];
    wire [PORT_W-1:0] pb_w = sync_r[2*PORT_W-1:PORT_W];
    wire [PORT_W-1:0] pc_w = sync_r[3*PORT_W-1:2*PORT_W];
    wire [PORT_W-1:0] pd_w = sync_r[4*PORT_W-1:3*PORT_W];
    wire sleep_exit_w = sleep_d_r & ~sync_r[RAW_W-1];
    wire hop_rise_w = sync_r[RAW_W-2] & ~hop_d_r;
    wire sync_evt_w = sleep_exit_w | hop_rise_w;

    // shared random source: pseudorandom input and both dithers
    reg [`CNM_FREQ_W-1:0] lfsr_r;
    always @(posedge clk_in) begin
        if (srst_in)
            lfsr_r <= `CNM_LFSR_SEED;
        else if (lfsr_r[0])
            lfsr_r <= (lfsr_r >> 1) ^ `CNM_LFSR_TAPS;
        else
            lfsr_r <= lfsr_r >> 1;
    end
    wire [PORT_W-1:0] pn_w = {1'b1, lfsr_r[MANT_W+EXP_W-1:0]};
    wire [PORT_W-1:0] pnq_w = {1'b1, lfsr_r[EXP_W-1:0], lfsr_r[31:32-MANT_W]};

    // crossbar, registered once
    reg [PORT_W-1:0] xi_w;
    reg [PORT_W-1:0] xq_w;
    always @* begin
        xi_w = {PORT_W{1'b0}};
        xq_w = {PORT_W{1'b0}};
        if (!complex_sel_in) begin
            case (source_sel_in)
                `CNM_SEL_A: xi_w = pa_w;
                `CNM_SEL_B: xi_w = pb_w;
                `CNM_SEL_C: xi_w = pc_w;
                `CNM_SEL_D: xi_w = pd_w;
                `CNM_SEL_PN_REAL: xi_w = pn_w;
                default: xi_w = {PORT_W{1'b0}};
            endcase
        end else begin
            case (source_sel_in)
                `CNM_SEL_AB: begin
                    xi_w = pa_w;
                    xq_w = pb_w;
                end
                `CNM_SEL_CD: begin
                    xi_w = pc_w;
                    xq_w = pd_w;
                end
                `CNM_SEL_PN_CPLX: begin
                    xi_w = pn_w;
                    xq_w = pnq_w;
                end
                default: xi_w = {PORT_W{1'b0}};
            endcase
        end
    end

    reg signed [MANT_W-1:0] ch_i_r;
    reg signed [MANT_W-1:0] ch_q_r;
    reg [EXP_W-1:0] ch_exp_r;
    reg ch_vld_r;
    reg ch_cplx_r;
    always @(posedge clk_in) begin
        if (srst_in) begin
            ch_i_r <= {MANT_W{1'b0}};
            ch_q_r <= {MANT_W{1'b0}};
            ch_exp_r <= {EXP_W{1'b0}};
            ch_vld_r <= 1'b0;
            ch_cplx_r <= 1'b0;
        end else begin
            ch_i_r <= xi_w[MANT_W-1:0];
            ch_q_r <= xq_w[MANT_W-1:0];
            ch_exp_r <= xi_w[MANT_W+EXP_W-1:MANT_W];
            ch_vld_r <= xi_w[PORT_W-1];
            ch_cplx_r <= complex_sel_in;
        end
    end

    // frequency shadow, hold-off and hop handling
    reg [1:0] state_r;
    reg [`CNM_HOLD_W-1:0] hold_cnt_r;
    reg [`CNM_FREQ_W-1:0] acc_r;
    wire hold_now_w = (frequency_update_delay_in == `CNM_HOLD_NOW) ||
                      (frequency_update_delay_in == `CNM_HOLD_ZERO);
    wire cnt_done_w = (state_r == ST_COUNT) && ch_vld_r && (hold_cnt_r == `CNM_HOLD_NOW);
    wire load_w = (sync_evt_w && hold_now_w) || cnt_done_w;

    always @(posedge clk_in) begin
        if (srst_in) begin
            state_r <= ST_IDLE;
            hold_cnt_r <= `CNM_HOLD_ZERO;
            tuning_shadow_out <= `CNM_FREQ_RST;
            tuning_active_out <= `CNM_FREQ_RST;
            update_pending_out <= 1'b0;
        end else begin
            if (tuning_word_wr_in)
                tuning_shadow_out <= tuning_word_in;
            if (load_w)
                tuning_active_out <= tuning_shadow_out;
            case (state_r)
                ST_IDLE: begin
                    if (sync_evt_w && !hold_now_w) begin
                        hold_cnt_r <= frequency_update_delay_in;
                        state_r <= ST_COUNT;
                        update_pending_out <= 1'b1;
                    end
                end
                ST_COUNT: begin
                    if (sync_evt_w && !hold_now_w) begin
                        hold_cnt_r <= frequency_update_delay_in;
                    end else if (sync_evt_w || cnt_done_w) begin
                        state_r <= ST_IDLE;
                        update_pending_out <= 1'b0;
                    end else if (ch_vld_r) begin
                        hold_cnt_r <= hold_cnt_r - `CNM_HOLD_NOW;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    update_pending_out <= 1'b0;
                end
            endcase
        end
    end

    // accumulator: signed word added as unsigned wraps the same way
    always @(posedge clk_in) begin
        if (srst_in)
            acc_r <= `CNM_FREQ_RST;
        else if (load_w && clear_acc_in)
            acc_r <= `CNM_FREQ_RST;
        else if (ch_vld_r)
            acc_r <= acc_r + tuning_active_out;
    end

    // phase word, offset and dither
    wire [`CNM_FREQ_W-1:0] pdith_w = phase_dither_en_in ?
        {{(`CNM_FREQ_W-`CNM_PDITH_W){1'b0}}, lfsr_r[`CNM_PDITH_W-1:0]} : `CNM_FREQ_RST;
    wire [`CNM_FREQ_W-1:0] acc_d_w = acc_r + pdith_w;
    wire [`CNM_PHASE_W-1:0] ofs_w = {oscillator_phase_offset_in,
        {(`CNM_PHASE_W-`CNM_POFS_W){1'b0}}};
    wire [`CNM_PHASE_W-1:0] phase_w =
        acc_d_w[`CNM_FREQ_W-1:`CNM_FREQ_W-`CNM_PHASE_W] + ofs_w;
    wire [`CNM_LUT_W-1:0] addr_w = phase_w[`CNM_PHASE_W-1:`CNM_PHASE_W-`CNM_LUT_W];

    // parabolic sine over a half turn; trades spur level for no table
    function [`CNM_AMP_W-1:0] nco_sin;
        input [`CNM_LUT_W-1:0] a;
        reg [`CNM_AMP_W-1:0] t;
        reg [34:0] p;
        reg [`CNM_AMP_W-1:0] m;
        begin
            t = a[`CNM_LUT_W-2:0];
            p = t * (`CNM_HALF_T - {1'b0, t});
            m = (p[32:16] > `CNM_AMP_MAX) ? `CNM_AMP_MAX : p[32:16];
            nco_sin = a[`CNM_LUT_W-1] ? (~m + 17'h00001) : m;
        end
    endfunction

    wire [`CNM_LUT_W-1:0] cos_addr_w = addr_w + `CNM_QUARTER;
    wire [`CNM_AMP_W-1:0] sin_raw_w = nco_sin(addr_w);
    wire [`CNM_AMP_W-1:0] cos_raw_w = nco_sin(cos_addr_w);
    wire signed [`CNM_AMP_W-1:0] sin_w = {sin_raw_w[`CNM_AMP_W-1:1],
        sin_raw_w[0] ^ (amp_dither_en_in & lfsr_r[8])};
    wire signed [`CNM_AMP_W-1:0] cos_w = {cos_raw_w[`CNM_AMP_W-1:1],
        cos_raw_w[0] ^ (amp_dither_en_in & lfsr_r[9])};

    // mixer, multiplying by exp(-j*phase)
    wire signed [MANT_W+`CNM_AMP_W-1:0] p_ic_w = ch_i_r * cos_w;
    wire signed [MANT_W+`CNM_AMP_W-1:0] p_is_w = ch_i_r * sin_w;
    wire signed [MANT_W+`CNM_AMP_W-1:0] p_qc_w = ch_q_r * cos_w;
    wire signed [MANT_W+`CNM_AMP_W-1:0] p_qs_w = ch_q_r * sin_w;
    reg signed [MANT_W+`CNM_AMP_W:0] mix_i_w;
    reg signed [MANT_W+`CNM_AMP_W:0] mix_q_w;
    always @* begin
        if (ch_cplx_r) begin
            mix_i_w = p_ic_w + p_qs_w;
            mix_q_w = p_qc_w - p_is_w;
        end else begin
            mix_i_w = p_ic_w;
            mix_q_w = -p_is_w;
        end
    end

    always @(posedge clk_in) begin
        if (srst_in) begin
            chan_i_out <= {MANT_W{1'b0}};
            chan_q_out <= {MANT_W{1'b0}};
            chan_exp_out <= {EXP_W{1'b0}};
            chan_cplx_out <= 1'b0;
            chan_vld_out <= 1'b0;
        end else begin
            chan_vld_out <= ch_vld_r;
            chan_exp_out <= ch_exp_r;
            chan_cplx_out <= ch_cplx_r;
            if (osc_bypass_in) begin
                chan_i_out <= ch_i_r;
                chan_q_out <= ch_q_r;
            end else begin
                chan_i_out <= mix_i_w[MANT_W+`CNM_AMP_W-1:`CNM_AMP_W];
                chan_q_out <= mix_q_w[MANT_W+`CNM_AMP_W-1:`CNM_AMP_W];
            end
        end
    end

endmodule // cnm_channel_nco_mixer
`default_nettype wire

// ### cnm_channel_nco_mixer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cnm_channel_nco_mixer_bench;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic fire = 1'b0;
    logic [11:0] seq = 12'h000;
    logic sleep = 1'b0;
    logic hop = 1'b0;
    logic wr = 1'b0;
    logic [31:0] word = 32'h0000_0000;
    logic [15:0] dly = 16'h0001;
    logic [15:0] pofs = 16'h0000;
    logic [2:0] sel = 3'h0;
    logic cplx = 1'b0;
    logic byp = 1'b1;
    logic clr = 1'b0;
    logic pdith = 1'b0;
    logic adith = 1'b0;
    logic [15:0] si;
    logic [15:0] sq;
    logic [2:0] sexp;
    logic scplx;
    logic [15:0] mant [0:3];
    logic [2:0] ex [0:3];
    logic vld;
    logic [31:0] shadow;
    logic [31:0] active;
    logic pend;
    logic [15:0] ci;
    logic [15:0] cq;
    logic [2:0] cexp;
    logic ccplx;
    logic cvld;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    always #2.5 clk_in = ~clk_in;
    cnm_adc_model cnm_adc_model_i (.clk_in(clk_in), .fire_in(fire), .seq_in(seq), .mant_out(mant), .exp_out(ex),
        .vld_out(vld));
    cnm_channel_nco_mixer cnm_channel_nco_mixer_i (.clk_in(clk_in), .srst_in(srst_in),
        .port_a_mant_in(mant[0]), .port_a_exp_in(ex[0]), .port_a_vld_in(vld),
        .port_b_mant_in(mant[1]), .port_b_exp_in(ex[1]), .port_b_vld_in(vld),
        .port_c_mant_in(mant[2]), .port_c_exp_in(ex[2]), .port_c_vld_in(vld),
        .port_d_mant_in(mant[3]), .port_d_exp_in(ex[3]), .port_d_vld_in(vld),
        .sleep_in(sleep), .hop_sync_in(hop), .tuning_word_wr_in(wr), .tuning_word_in(word),
        .frequency_update_delay_in(dly), .oscillator_phase_offset_in(pofs), .source_sel_in(sel),
        .complex_sel_in(cplx), .osc_bypass_in(byp), .clear_acc_in(clr), .phase_dither_en_in(pdith),
        .amp_dither_en_in(adith), .tuning_shadow_out(shadow), .tuning_active_out(active),
        .update_pending_out(pend), .chan_i_out(ci), .chan_q_out(cq), .chan_exp_out(cexp),
        .chan_cplx_out(ccplx), .chan_vld_out(cvld));
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic put(input logic [31:0] w);
        word = w;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
    endtask
    task automatic pulse_hop();
        hop = 1'b1;
        step(2);
        hop = 1'b0;
        step(6);
    endtask
    // output data follows the port every clock, so it is captured in the valid cycle
    task automatic shoot(input logic [11:0] s);
        seq = s;
        fire = 1'b1;
        step(1);
        fire = 1'b0;
        step(4);
        chk(cvld === 1'b1, "sample valid");
        si = ci;
        sq = cq;
        sexp = cexp;
        scplx = ccplx;
        step(4);
    endtask
    task automatic t_regs();
        chk(shadow === 32'h0 && active === 32'h0 && pend === 1'b0 && cvld === 1'b0, "reset state");
        put(32'h8000_0000);
        put(32'h7FFF_FFFF);
        step(1);
        chk(shadow === 32'h7FFF_FFFF && active === 32'h0, "shadow only");
        pulse_hop();
        chk(active === 32'h7FFF_FFFF, "immediate hop");
    endtask
    task automatic t_holdoff();
        put(32'h4000_0000);
        dly = 16'h0003;
        pulse_hop();
        chk(pend === 1'b1 && active === 32'h7FFF_FFFF, "countdown start");
        shoot(12'h111);
        shoot(12'h222);
        chk(pend === 1'b1 && active === 32'h7FFF_FFFF, "early load");
        shoot(12'h333);
        chk(pend === 1'b0 && active === 32'h4000_0000, "countdown load");
        dly = 16'h0001;
        sleep = 1'b1;
        step(4);
        put(32'hE000_0000);
        step(4);
        chk(active === 32'h4000_0000, "asleep load");
        sleep = 1'b0;
        step(8);
        chk(active === 32'hE000_0000, "sleep exit load");
    endtask
    task automatic t_route();
        for (int k = 0; k < 4; k++) begin
            sel = 3'(k);
            shoot(12'h5A0);
            chk(si === {4'(k), 12'h5A0} && sq === 16'h0 && sexp === 3'(k + 1) && scplx === 1'b0, "real route");
        end
        cplx = 1'b1;
        for (int k = 0; k < 2; k++) begin
            sel = 3'(k);
            shoot(12'h3C5);
            chk(si === {4'(2 * k), 12'h3C5} && sq === {4'(2 * k + 1), 12'h3C5} && sexp === 3'(2 * k + 1), "pair");
        end
    endtask
    task automatic t_pn();
        int n;
        for (int k = 0; k < 2; k++) begin
            cplx = 1'(k);
            sel = k ? 3'h2 : 3'h4;
            step(6);
            n = 0;
            repeat (8) begin
                n += (cvld === 1'b1);
                step(1);
            end
            chk(n == 8, "pseudorandom stream");
        end
    endtask
    task automatic t_mix();
        byp = 1'b0;
        clr = 1'b1;
        cplx = 1'b0;
        sel = 3'h0;
        put(32'h0);
        pulse_hop();
        shoot(12'h400);
        chk(active === 32'h0 && si === 16'h01FF && sq === 16'h0000, "real mix at phase zero");
        pdith = 1'b1;
        adith = 1'b1;
        shoot(12'h400);
        chk(si === 16'h01FF && (sq === 16'h0000 || sq === 16'hFFFF), "dithered mix");
        pdith = 1'b0;
        adith = 1'b0;
        pofs = 16'h4000;
        shoot(12'h400);
        chk(si === 16'h0000 && sq === 16'hFE00, "quarter turn offset");
    endtask
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            $display("mismatch at %0t: timeout", $time);
            summarize();
        end
    end
    initial begin
        step(12);
        srst_in = 1'b0;
        step(4);
        t_regs();
        t_holdoff();
        t_route();
        t_pn();
        t_mix();
        summarize();
    end
endmodule // cnm_channel_nco_mixer_bench
`default_nettype wire

// ### cnm_channel_nco_mixer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cnm_nco_checker #(parameter MANT_W = 16, parameter EXP_W = 3) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // watched inputs
    input wire logic [MANT_W-1:0] port_a_mant_in,
    input wire logic [EXP_W-1:0] port_a_exp_in,
    input wire logic port_a_vld_in,
    input wire logic [MANT_W-1:0] port_b_mant_in,
    input wire logic hop_sync_in,
    input wire logic tuning_word_wr_in,
    input wire logic [31:0] tuning_word_in,
    input wire logic [15:0] frequency_update_delay_in,
    input wire logic [2:0] source_sel_in,
    input wire logic complex_sel_in,
    input wire logic osc_bypass_in,
    // watched outputs
    input wire logic [31:0] tuning_shadow_out,
    input wire logic [31:0] tuning_active_out,
    input wire logic update_pending_out,
    input wire logic [MANT_W-1:0] chan_i_out,
    input wire logic [MANT_W-1:0] chan_q_out,
    input wire logic [EXP_W-1:0] chan_exp_out,
    input wire logic chan_cplx_out,
    input wire logic chan_vld_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    a_shadow_write: assert property (tuning_word_wr_in |=> tuning_shadow_out == $past(tuning_word_in))
        else $error("shadow missed write");
    a_shadow_hold: assert property (!tuning_word_wr_in |=> $stable(tuning_shadow_out))
        else $error("shadow changed without write");
    a_active_source: assert property ($changed(tuning_active_out) |-> tuning_active_out == $past(tuning_shadow_out))
        else $error("active loaded from elsewhere");
    a_pending_load: assert property ($fell(update_pending_out) |-> tuning_active_out == $past(tuning_shadow_out))
        else $error("countdown end without load");
    a_pending_cause: assert property ($rose(update_pending_out) |-> frequency_update_delay_in > 16'h0001)
        else $error("countdown for immediate value");
    a_hop_now: assert property ($rose(hop_sync_in) && frequency_update_delay_in == 16'h0001
        |-> ##[3:5] tuning_active_out == tuning_shadow_out) else $error("immediate hop not loaded");
    a_real_route: assert property (!complex_sel_in && source_sel_in == 3'h0 && osc_bypass_in && port_a_vld_in
        |-> ##4 chan_vld_out && chan_i_out == $past(port_a_mant_in, 4) && chan_exp_out == $past(port_a_exp_in, 4))
        else $error("port a route wrong");
    a_pair_route: assert property (complex_sel_in && source_sel_in == 3'h0 && osc_bypass_in && port_a_vld_in
        |-> ##4 chan_cplx_out && chan_q_out == $past(port_b_mant_in, 4) && chan_exp_out == $past(port_a_exp_in, 4))
        else $error("pair route wrong");
    a_pn_stream: assert property ((!complex_sel_in && source_sel_in == 3'h4) [*6] |-> chan_vld_out)
        else $error("pseudorandom stream gap");
    c_hop_now: cover property ($rose(hop_sync_in) && frequency_update_delay_in == 16'h0001);
    c_countdown: cover property ($fell(update_pending_out));
    c_pair: cover property (chan_vld_out && chan_cplx_out);
endmodule // cnm_nco_checker
bind cnm_channel_nco_mixer cnm_nco_checker #(.MANT_W(MANT_W), .EXP_W(EXP_W)) cnm_nco_checker_i (.clk_in, .srst_in,
    .port_a_mant_in, .port_a_exp_in, .port_a_vld_in, .port_b_mant_in, .hop_sync_in, .tuning_word_wr_in,
    .tuning_word_in, .frequency_update_delay_in, .source_sel_in, .complex_sel_in, .osc_bypass_in,
    .tuning_shadow_out, .tuning_active_out, .update_pending_out, .chan_i_out, .chan_q_out, .chan_exp_out,
    .chan_cplx_out, .chan_vld_out);
`default_nettype wire

// ### cnm_defines.vh
`ifndef CNM_DEFINES_VH
`define CNM_DEFINES_VH
`define CNM_FREQ_W 32
`define CNM_HOLD_W 16
`define CNM_POFS_W 16
`define CNM_PHASE_W 20
`define CNM_LUT_W 18
`define CNM_AMP_W 17
`define CNM_MANT_W 16
`define CNM_EXP_W 3
`define CNM_SEL_W 3
`define CNM_SEL_A 3'h0
`define CNM_SEL_B 3'h1
`define CNM_SEL_C 3'h2
`define CNM_SEL_D 3'h3
`define CNM_SEL_PN_REAL 3'h4
`define CNM_SEL_AB 3'h0
`define CNM_SEL_CD 3'h1
`define CNM_SEL_PN_CPLX 3'h2
`define CNM_LFSR_TAPS 32'h80200003
`define CNM_LFSR_SEED 32'h00000001
`define CNM_FREQ_RST 32'h00000000
`define CNM_HOLD_NOW 16'h0001
`define CNM_HOLD_ZERO 16'h0000
`define CNM_QUARTER 18'h10000
`define CNM_HALF_T 18'h20000
`define CNM_AMP_MAX 17'h0FFFF
`define CNM_PDITH_W 4
`endif
